// file: design/stp_regs.vh
// Constants for the transfer-parameter register group: offsets, fields,
// reset values and code points. Included by every design file of the block.
`ifndef STP_REGS_VH
`define STP_REGS_VH

// Register offsets on the 5-bit host register port.
`define STP_OFF_TARGET_ID    5'h04
`define STP_OFF_BYTE_LOW     5'h0a
`define STP_OFF_CTRL_VIEW    5'h0b
`define STP_OFF_XFER_KIND    5'h0c
`define STP_OFF_SYNC_PERIOD  5'h0d
`define STP_OFF_SYNC_OFFSET  5'h0e
`define STP_OFF_WINDOW       5'h0f
`define STP_OFF_BYTE_RING    5'h0f
`define STP_WIN_ADDR_BIT     4

// Field positions and widths.
`define STP_KIND_SYNC_BIT    7
`define STP_ID_W             3
`define STP_ID_COUNT         8
`define STP_CODE_W           5
`define STP_RING_W           6
`define STP_WIN_KIND_HI      7
`define STP_WIN_KIND_LO      6
`define STP_WIN_PAGE_HI      3
`define STP_WIN_PAGE_LO      0

// Window kinds.
`define STP_WIN_MCS          2'h0
`define STP_WIN_SCAM         2'h1
`define STP_WIN_PROGRAM      2'h2
`define STP_WIN_SETUP        2'h3

// Reset values.
`define STP_RST_BYTE         8'h00
`define STP_RST_CODE         5'h00
`define STP_RST_RING         6'h00

// Period and offset code points.
`define STP_CODE_FULL        5'h00
`define STP_CODE_BANNED      5'h01
`define STP_FULL_COUNT       6'h20
`define STP_CNT_ZERO         6'h00
`define STP_CNT_ONE          6'h01

`endif

// file: design/stp_period_gen.v
// REQ/ACK period generator for synchronous data transfer.
// Assumes the period code is steady while run is high; runs on core_clk.
`timescale 1ns/10ps
`include "stp_regs.vh"

module stp_period_gen (
  // Clock and reset.
  input  wire                     core_clk,
  input  wire                     resetn,
  // Control.
  input  wire                     run,
  input  wire [`STP_CODE_W-1:0]   period_code,
  // Strobe outputs.
  output reg                      req_ack_level,
  output reg                      period_tick
);

  reg  [5:0] cnt;
  reg  [5:0] next_cnt;
  wire [5:0] total;
  wire [5:0] half_up;

  // Code 0 stands for a period of 32; asserted part is the rounded-up half.
  assign total   = (period_code == `STP_CODE_FULL) ? `STP_FULL_COUNT : {1'b0, period_code}; // see [RULE_05]
  assign half_up = (total + `STP_CNT_ONE) >> 1; // see [RULE_05]

  // Wrap the counter once per period so one byte slot fits each period.
  always @* begin
    if (cnt == total - `STP_CNT_ONE) begin
      next_cnt = `STP_CNT_ZERO; // see [RULE_07]
    end else begin
      next_cnt = cnt + `STP_CNT_ONE;
    end
  end

  // The banned code holds the strobe negated rather than guess a timing.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt           <= `STP_CNT_ZERO;
      req_ack_level <= 1'b0;
      period_tick   <= 1'b0;
    end else if (!run || period_code == `STP_CODE_BANNED) begin // see [RULE_05]
      cnt           <= `STP_CNT_ZERO;
      req_ack_level <= 1'b0;
      period_tick   <= 1'b0;
    end else begin
      cnt           <= next_cnt;
      req_ack_level <= (next_cnt < half_up); // see [RULE_05]
      period_tick   <= (next_cnt == `STP_CNT_ZERO);
    end
  end

endmodule // stp_period_gen

// file: design/stp_byte_ring.v
// Six-bit ring counter of transferred bytes.
// Assumes load and dec are single-cycle pulses on core_clk.
`timescale 1ns/10ps
`include "stp_regs.vh"

module stp_byte_ring (
  // Clock and reset.
  input  wire                     core_clk,
  input  wire                     resetn,
  input  wire                     clear,
  // Counter control.
  input  wire                     load,
  input  wire [`STP_RING_W-1:0]   load_value,
  input  wire                     dec,
  // Count.
  output reg  [`STP_RING_W-1:0]   count
);

  wire [`STP_RING_W-1:0] base;

  // A byte in the load cycle is counted against the fresh value, not lost.
  assign base = load ? load_value : count; // see [RULE_13]

  // Plain 6-bit arithmetic wraps below zero to 63.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      count <= `STP_RST_RING;
    end else if (clear) begin
      count <= `STP_RST_RING;
    end else begin
      count <= base - {{(`STP_RING_W-1){1'b0}}, dec}; // see [RULE_13] see [RULE_20]
    end
  end

endmodule // stp_byte_ring

// file: design/stp_regs_top.v
// Transfer-parameter register group of the protocol controller: control
// signal view, per-target transfer mode, period and offset, window selector
// and the transferred-byte ring counter.
// Assumes a host register port synchronous to core_clk with one-cycle
// read and write strobes, and a sequencer that pulses byte events.
//
// Notes on behaviour
// [RULE_01] Status bit reads 1 while signal asserted.
// [RULE_02] Kind bit 7: 1 synchronous, 0 asynchronous.
// [RULE_03] Mode kept per target ID, recalled.
// [RULE_04] Period kept per target ID, reapplied.
// [RULE_05] Period N: ceil/floor halves; 0=32; 1 banned.
// [RULE_06] Software keeps period code above clock minimum.
// [RULE_07] One byte per programmed period.
// [RULE_08] Offset code 1-31 literal, 0 means 32.
// [RULE_09] Window bits 7:6 choose window kind.
// [RULE_10] Window bits 3:0 give 16-byte page.
// [RULE_11] Software writes zeros to unused window bits.
// [RULE_12] Software never selects absent SCAM window.
// [RULE_13] Ring loads byte count low, decrements.
// [RULE_14] Counts buffer bytes or data bytes by phase.
// [RULE_15] Auto modes accumulate across phases.
// [RULE_16] Abnormal end invalidates held data bytes.
// [RULE_17] Host waits for busy clear before status.
// [RULE_18] Host loads counts before data command.
// [RULE_19] Host loads message byte count when needed.
// [RULE_20] Ring wraps modulo 64.
`timescale 1ns/10ps
`include "stp_regs.vh"

module stp_regs_top (
  // Clock and reset.
  input  wire                     core_clk,
  input  wire                     resetn,
  input  wire                     sw_reset,
  // Host register port.
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  input  wire [4:0]               reg_addr,
  input  wire [7:0]               reg_wdata,
  output reg  [7:0]               reg_rdata,
  // Bus control signals and diagnostic emulation.
  input  wire [7:0]               scsi_ctl_pin,
  input  wire                     diag_mode,
  input  wire [7:0]               diag_ctl,
  // Sequencer events.
  input  wire                     sync_run,
  input  wire                     data_phase,
  input  wire                     auto_mode,
  input  wire                     byte_load,
  input  wire                     mcs_byte,
  input  wire                     data_byte,
  input  wire                     abnormal_end,
  // Active transfer parameters.
  output reg  [`STP_ID_W-1:0]     target_id,
  output reg                      sync_mode,
  output reg  [`STP_CODE_W-1:0]   sync_period_code,
  output reg  [`STP_RING_W-1:0]   max_offset,
  output wire                     req_ack_level,
  output wire                     period_tick,
  // Window mapping.
  output reg  [1:0]               window_kind,
  output reg  [3:0]               window_page,
  output reg                      win_access,
  output reg  [7:0]               win_mem_addr,
  // Byte accounting.
  output wire [`STP_RING_W-1:0]   byte_ring,
  output reg                      data_reg_invalid
);

  // Per-target parameter store.
  reg                     kind_mem   [0:`STP_ID_COUNT-1];
  reg [`STP_CODE_W-1:0]   period_mem [0:`STP_ID_COUNT-1];
  reg [`STP_CODE_W-1:0]   offset_mem [0:`STP_ID_COUNT-1];
  integer                 i;

  // Control pin synchroniser and filtered view.
  reg [7:0]               ctl_s1;
  reg [7:0]               ctl_s2;
  reg [7:0]               ctl_s3;
  reg [7:0]               ctl_seen;
  reg [7:0]               ctrl_view;

  // Host-side shadow state.
  reg [7:0]               window_selector;
  reg [`STP_RING_W-1:0]   byte_count_low;
  reg [7:0]               next_rdata;

  // Decoded strobes.
  wire                    wr_id;
  wire                    wr_kind;
  wire                    wr_period;
  wire                    wr_offset;
  wire                    wr_window;
  wire                    wr_byte_low;
  wire                    ring_load;
  wire                    ring_dec;
  wire                    win_hit;
  wire [`STP_ID_W-1:0]    new_id;
  wire [`STP_CODE_W-1:0]  sel_offset;

  assign wr_id       = reg_wr && (reg_addr == `STP_OFF_TARGET_ID);
  assign wr_kind     = reg_wr && (reg_addr == `STP_OFF_XFER_KIND);
  assign wr_period   = reg_wr && (reg_addr == `STP_OFF_SYNC_PERIOD);
  assign wr_offset   = reg_wr && (reg_addr == `STP_OFF_SYNC_OFFSET);
  assign wr_window   = reg_wr && (reg_addr == `STP_OFF_WINDOW);
  assign wr_byte_low = reg_wr && (reg_addr == `STP_OFF_BYTE_LOW);
  assign win_hit     = (reg_wr || reg_rd) && reg_addr[`STP_WIN_ADDR_BIT];
  assign new_id      = reg_wdata[`STP_ID_W-1:0];

  // Pin samples pass three flops; a change is taken once stages two and
  // three agree, so a single-cycle glitch never reaches the view.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctl_s1   <= `STP_RST_BYTE;
      ctl_s2   <= `STP_RST_BYTE;
      ctl_s3   <= `STP_RST_BYTE;
      ctl_seen <= `STP_RST_BYTE;
    end else begin
      ctl_s1 <= scsi_ctl_pin;
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
      if (ctl_s2 == ctl_s3) begin
        ctl_seen <= ctl_s3;
      end
    end
  end

  // In diagnostic mode the emulated signals are the ones on the bus, so
  // the view follows them instead of the idle pins.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_view <= `STP_RST_BYTE;
    end else begin
      ctrl_view <= diag_mode ? diag_ctl : ctl_seen; // see [RULE_01]
    end
  end

  // Per-target store. Writes land in the slot of the ID already selected,
  // so the host must select the target before writing its parameters.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < `STP_ID_COUNT; i = i + 1) begin
        kind_mem[i]   <= 1'b0;
        period_mem[i] <= `STP_RST_CODE;
        offset_mem[i] <= `STP_RST_CODE;
      end
    end else if (sw_reset) begin
      for (i = 0; i < `STP_ID_COUNT; i = i + 1) begin
        kind_mem[i]   <= 1'b0; // see [RULE_03]
        period_mem[i] <= `STP_RST_CODE; // see [RULE_04]
        offset_mem[i] <= `STP_RST_CODE;
      end
    end else begin
      if (wr_kind) begin
        kind_mem[target_id] <= reg_wdata[`STP_KIND_SYNC_BIT]; // see [RULE_03]
      end
      if (wr_period) begin
        period_mem[target_id] <= reg_wdata[`STP_CODE_W-1:0]; // see [RULE_04]
      end
      if (wr_offset) begin
        offset_mem[target_id] <= reg_wdata[`STP_CODE_W-1:0];
      end
    end
  end

  // Active parameters: a write to the ID register recalls the stored set,
  // a parameter write for the current ID takes effect at once.
  assign sel_offset = wr_offset ? reg_wdata[`STP_CODE_W-1:0]
                    : (wr_id ? offset_mem[new_id] : offset_mem[target_id]);

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      target_id        <= {`STP_ID_W{1'b0}};
      sync_mode        <= 1'b0;
      sync_period_code <= `STP_RST_CODE;
      max_offset       <= `STP_FULL_COUNT;
    end else if (sw_reset) begin
      target_id        <= {`STP_ID_W{1'b0}};
      sync_mode        <= 1'b0;
      sync_period_code <= `STP_RST_CODE;
      max_offset       <= `STP_FULL_COUNT;
    end else begin
      if (wr_id) begin
        target_id        <= new_id;
        sync_mode        <= kind_mem[new_id]; // see [RULE_03]
        sync_period_code <= period_mem[new_id]; // see [RULE_04]
      end else begin
        if (wr_kind) begin
          sync_mode <= reg_wdata[`STP_KIND_SYNC_BIT]; // see [RULE_02]
        end
        if (wr_period) begin
          sync_period_code <= reg_wdata[`STP_CODE_W-1:0];
        end
      end
      // Offset code 0 is the largest window, 32 outstanding strobes.
      if (sel_offset == `STP_CODE_FULL) begin
        max_offset <= `STP_FULL_COUNT; // see [RULE_08]
      end else begin
        max_offset <= {1'b0, sel_offset}; // see [RULE_08]
      end
    end
  end

  // Window selector and the low byte count that seeds the ring counter.
  // Reserved bits 5:4 are stored as written; software keeps them zero.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      window_selector <= `STP_RST_BYTE;
      byte_count_low  <= `STP_RST_RING;
    end else begin
      if (wr_window) begin
        window_selector <= reg_wdata;
      end
      if (wr_byte_low) begin
        byte_count_low <= reg_wdata[`STP_RING_W-1:0];
      end
    end
  end

  // Map accesses at 10h-1Fh onto the selected window. The buffer page uses
  // one selector bit, program memory all four; other windows use none.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      window_kind  <= `STP_WIN_MCS;
      window_page  <= 4'h0;
      win_access   <= 1'b0;
      win_mem_addr <= 8'h00;
    end else begin
      window_kind <= window_selector[`STP_WIN_KIND_HI:`STP_WIN_KIND_LO]; // see [RULE_09]
      window_page <= window_selector[`STP_WIN_PAGE_HI:`STP_WIN_PAGE_LO]; // see [RULE_10]
      win_access  <= win_hit;
      case (window_selector[`STP_WIN_KIND_HI:`STP_WIN_KIND_LO])
        `STP_WIN_MCS: begin
          win_mem_addr <= {3'h0, window_selector[0], reg_addr[3:0]}; // see [RULE_10]
        end
        `STP_WIN_PROGRAM: begin
          win_mem_addr <= {window_selector[`STP_WIN_PAGE_HI:`STP_WIN_PAGE_LO], reg_addr[3:0]}; // see [RULE_10]
        end
        default: begin
          win_mem_addr <= {4'h0, reg_addr[3:0]}; // see [RULE_09]
        end
      endcase
    end
  end

  // Byte accounting. In automatic modes the count is not reseeded between
  // phases, so the ring shows the total taken over all of them.
  assign ring_load = byte_load && !auto_mode; // see [RULE_15]
  assign ring_dec  = data_phase ? data_byte : mcs_byte; // see [RULE_14]

  stp_byte_ring u_ring (
    .core_clk   (core_clk),
    .resetn     (resetn),
    .clear      (sw_reset),
    .load       (ring_load),
    .load_value (byte_count_low),
    .dec        (ring_dec),
    .count      (byte_ring)
  );

  // Bytes still held at an abnormal end are unusable; the flag stays until
  // the next count load or software reset. A new abort in the load cycle wins.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_reg_invalid <= 1'b0;
    end else if (abnormal_end) begin
      data_reg_invalid <= 1'b1; // see [RULE_16]
    end else if (byte_load || sw_reset) begin
      data_reg_invalid <= 1'b0;
    end
  end

  // REQ/ACK timing only runs for synchronous targets.
  stp_period_gen u_period (
    .core_clk      (core_clk),
    .resetn        (resetn),
    .run           (sync_run && sync_mode), // see [RULE_02]
    .period_code   (sync_period_code),
    .req_ack_level (req_ack_level),
    .period_tick   (period_tick)
  );

  // Read data mux. Unmapped offsets read zero.
  always @* begin
    case (reg_addr)
      `STP_OFF_CTRL_VIEW: begin
        next_rdata = ctrl_view;
      end
      `STP_OFF_XFER_KIND: begin
        next_rdata = {sync_mode, 7'h00};
      end
      `STP_OFF_SYNC_PERIOD: begin
        next_rdata = {3'h0, sync_period_code};
      end
      `STP_OFF_SYNC_OFFSET: begin
        next_rdata = {3'h0, sel_offset};
      end
      `STP_OFF_BYTE_RING: begin
        next_rdata = {2'h0, byte_ring};
      end
      default: begin
        next_rdata = `STP_RST_BYTE;
      end
    endcase
  end

  // Read data is captured on the strobe and held until the next read.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= `STP_RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // stp_regs_top

// file: test/stp_regs_sva.sv
// Checker for the transfer-parameter register group, bound to stp_regs_top.
// Assumes host strobes and byte events are single-cycle pulses on core_clk.
`timescale 1ns/10ps
`include "stp_regs.vh"
module stp_regs_sva (
  // Clock and reset.
  input wire                   core_clk,
  input wire                   resetn,
  input wire                   sw_reset,
  // Host port.
  input wire                   reg_wr,
  input wire                   reg_rd,
  input wire [4:0]             reg_addr,
  input wire [7:0]             reg_wdata,
  input wire [7:0]             reg_rdata,
  // View and sequencer inputs.
  input wire                   diag_mode,
  input wire [7:0]             diag_ctl,
  input wire                   sync_run,
  input wire                   data_phase,
  input wire                   auto_mode,
  input wire                   byte_load,
  input wire                   mcs_byte,
  input wire                   data_byte,
  input wire                   abnormal_end,
  // Outputs under watch.
  input wire                   sync_mode,
  input wire [`STP_CODE_W-1:0] sync_period_code,
  input wire [`STP_RING_W-1:0] max_offset,
  input wire                   req_ack_level,
  input wire                   period_tick,
  input wire [1:0]             window_kind,
  input wire [3:0]             window_page,
  input wire                   win_access,
  input wire [`STP_RING_W-1:0] byte_ring,
  input wire                   data_reg_invalid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // A write with a quiet cycle after it, so a late-landing output is still judged fairly.
  sequence s_lone_wr(a); reg_wr && reg_addr == a && !sw_reset ##1 !reg_wr && !sw_reset; endsequence
  sequence s_hi2; req_ack_level [*2]; endsequence
  sequence s_lo2; !req_ack_level [*2]; endsequence
  property p_kind; s_lone_wr(`STP_OFF_XFER_KIND) |=> sync_mode == $past(reg_wdata[7], 2); endproperty
  property p_period; s_lone_wr(`STP_OFF_SYNC_PERIOD) |=> sync_period_code == $past(reg_wdata[4:0], 2); endproperty
  property p_offset; s_lone_wr(`STP_OFF_SYNC_OFFSET) |=>
    max_offset == (($past(reg_wdata[4:0], 2) == 5'h00) ? 6'h20 : {1'b0, $past(reg_wdata[4:0], 2)}); endproperty
  property p_win; s_lone_wr(`STP_OFF_WINDOW) |=>
    window_kind == $past(reg_wdata[7:6], 2) && window_page == $past(reg_wdata[3:0], 2); endproperty
  property p_dec; (data_phase ? data_byte : mcs_byte) && (auto_mode || !byte_load) && !sw_reset |=>
    byte_ring == $past(byte_ring) - 6'h01; endproperty
  property p_auto; auto_mode && byte_load && !data_byte && !mcs_byte && !sw_reset |=> $stable(byte_ring); endproperty
  property p_abort; abnormal_end && !sw_reset |=> data_reg_invalid; endproperty
  property p_view; reg_rd && reg_addr == `STP_OFF_CTRL_VIEW && diag_mode && $past(diag_mode) && $stable(diag_ctl)
    |=> reg_rdata == $past(diag_ctl); endproperty
  property p_tick_high; period_tick |-> req_ack_level; endproperty
  // A stop of the run aborts the check, since the generator may cut the period short.
  property p_period4; @(posedge core_clk) disable iff (!resetn || !sync_run)
    period_tick && sync_period_code == 5'h04 |-> s_hi2 ##1 s_lo2 ##1 period_tick; endproperty
  property p_banned; sync_period_code == 5'h01 && $past(sync_period_code, 2) == 5'h01 |-> !req_ack_level; endproperty
  property p_win_acc; reg_wr || reg_rd |=> win_access == $past(reg_addr[4]); endproperty
  a_kind: assert property (p_kind) else $error("transfer kind not taken from write");
  a_period: assert property (p_period) else $error("period code not taken from write");
  a_offset: assert property (p_offset) else $error("offset count wrong");
  a_win: assert property (p_win) else $error("window fields wrong");
  a_dec: assert property (p_dec) else $error("ring did not step down");
  a_auto: assert property (p_auto) else $error("ring reloaded in auto mode");
  a_abort: assert property (p_abort) else $error("held data not marked invalid");
  a_view: assert property (p_view) else $error("control view wrong in diag mode");
  a_tick_high: assert property (p_tick_high) else $error("period does not open asserted");
  a_period4: assert property (p_period4) else $error("period of code 4 wrong");
  a_banned: assert property (p_banned) else $error("strobe on banned code");
  a_win_acc: assert property (p_win_acc) else $error("window access flag wrong");
endmodule // stp_regs_sva

bind stp_regs_top stp_regs_sva i_sva (.*);

// file: test/stp_bus_partner.sv
// Model of the bus device at the far side: drives control pins, takes a byte per REQ period.
// Assumes its byte pulse is merged into the block's data byte input by the bench.
`timescale 1ns/10ps
module stp_bus_partner (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       resetn,
  // Settings from the bench.
  input  wire       drive_en,
  input  wire [7:0] drive_val,
  input  wire       slow,
  // Block side.
  input  wire       period_tick,
  output wire [7:0] scsi_ctl_pin,
  output reg        byte_done
);
  reg [1:0] pend;
  // Released lines are terminated, so they read as negated.
  assign scsi_ctl_pin = drive_en ? drive_val : 8'h00;
  // One byte per period; a slow device answers two cycles late.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pend <= 2'h0;
      byte_done <= 1'b0;
    end else begin
      pend <= {pend[0], period_tick};
      byte_done <= slow ? pend[1] : period_tick;
    end
  end
endmodule // stp_bus_partner

// file: test/stp_regs_top_tb.sv
// Self-checking bench of stp_regs_top with the bus partner model.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/10ps
module stp_regs_top_tb;
  reg        core_clk = 0, resetn = 0, sw_reset = 0, reg_wr = 0, reg_rd = 0, diag_mode = 0;
  reg  [4:0] reg_addr = 5'h00;
  reg  [7:0] reg_wdata = 8'h00, diag_ctl = 8'h00, drv_val = 8'h00;
  reg        sync_run = 0, data_phase = 0, auto_mode = 0, drv_en = 0, slow = 0;
  reg        byte_load = 0, mcs_byte = 0, tb_byte = 0, abnormal_end = 0;
  wire [7:0] reg_rdata, scsi_ctl_pin, win_mem_addr;
  wire [2:0] target_id;
  wire [4:0] sync_period_code;
  wire [5:0] max_offset, byte_ring;
  wire [1:0] window_kind;
  wire [3:0] window_page;
  wire       sync_mode, req_ack_level, period_tick, data_reg_invalid, p_byte;
  integer    failures = 0, check_count = 0, ticks = 0;

  stp_regs_top i_dut (.core_clk(core_clk), .resetn(resetn), .sw_reset(sw_reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .scsi_ctl_pin(scsi_ctl_pin), .diag_mode(diag_mode), .diag_ctl(diag_ctl), .sync_run(sync_run),
    .data_phase(data_phase), .auto_mode(auto_mode), .byte_load(byte_load), .mcs_byte(mcs_byte),
    .data_byte(tb_byte | p_byte), .abnormal_end(abnormal_end), .target_id(target_id),
    .sync_mode(sync_mode), .sync_period_code(sync_period_code), .max_offset(max_offset),
    .req_ack_level(req_ack_level), .period_tick(period_tick), .window_kind(window_kind),
    .window_page(window_page), .win_access(), .win_mem_addr(win_mem_addr), .byte_ring(byte_ring),
    .data_reg_invalid(data_reg_invalid));
  stp_bus_partner i_partner (.core_clk(core_clk), .resetn(resetn), .drive_en(drv_en), .drive_val(drv_val),
    .slow(slow), .period_tick(period_tick), .scsi_ctl_pin(scsi_ctl_pin), .byte_done(p_byte));

  // Clock and the count of REQ periods seen.
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (period_tick === 1'b1) ticks = ticks + 1;

  task check(input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  // Bus cycles hold an extra quiet edge, so registered outputs have landed on return.
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
      #1;
    end
  endtask
  task rd(input [4:0] a, input [7:0] exp);
    begin
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
      #1;
      check(reg_rdata, exp);
    end
  endtask
  // Event pulses, bits are load, buffer byte, data byte and abort.
  task ev(input [3:0] m);
    begin
      @(posedge core_clk);
      {byte_load, mcs_byte, tb_byte, abnormal_end} <= m;
      @(posedge core_clk);
      {byte_load, mcs_byte, tb_byte, abnormal_end} <= 4'h0;
      @(posedge core_clk);
      #1;
    end
  endtask
  task t_per_id;
    integer i;
    begin
      check(max_offset, 32'h20);
      rd(5'h05, 8'h00);
      for (i = 1; i < 4; i = i + 1) begin
        wr(5'h04, i[7:0]);
        wr(5'h0c, {i[0], 7'h00});
        wr(5'h0d, i[7:0] + 8'h03);
        wr(5'h0e, (i == 3) ? 8'h00 : i[7:0]);
      end
      for (i = 3; i > 0; i = i - 1) begin
        wr(5'h04, i[7:0]);
        check(target_id, i);
        check(sync_mode, i[0]);
        check(sync_period_code, i + 3);
        check(max_offset, (i == 3) ? 32 : i);
        rd(5'h0d, i[7:0] + 8'h03);
      end
      @(posedge core_clk);
      sw_reset <= 1'b1;
      @(posedge core_clk);
      sw_reset <= 1'b0;
      wr(5'h04, 8'h03);
      check({sync_mode, sync_period_code}, 0);
      wr(5'h0e, 8'h1f);
      check(max_offset, 31);
    end
  endtask
  task t_view;
    begin
      @(posedge core_clk);
      drv_val <= 8'ha5;
      drv_en <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd(5'h0b, 8'ha5);
      @(posedge core_clk);
      diag_ctl <= 8'h3c;
      diag_mode <= 1'b1;
      repeat (2) @(posedge core_clk);
      rd(5'h0b, 8'h3c);
      @(posedge core_clk);
      diag_mode <= 1'b0;
      drv_en <= 1'b0;
    end
  endtask
  task t_ring;
    begin
      wr(5'h0a, 8'hc2);
      @(posedge core_clk);
      data_phase <= 1'b1;
      ev(4'h8);
      check(byte_ring, 2);
      ev(4'h2);
      ev(4'h2);
      ev(4'h2);
      check(byte_ring, 63);
      ev(4'h4);
      check(byte_ring, 63);
      @(posedge core_clk);
      data_phase <= 1'b0;
      auto_mode <= 1'b1;
      ev(4'h4);
      ev(4'h8);
      check(byte_ring, 62);
      @(posedge core_clk);
      auto_mode <= 1'b0;
      ev(4'h1);
      check(data_reg_invalid, 1);
      ev(4'h8);
      check(data_reg_invalid, 0);
      rd(5'h0f, 8'h02);
      ev(4'h9);
      check(data_reg_invalid, 1);
    end
  endtask
  task t_window;
    integer i;
    reg [3:0] pg;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        pg = (i == 2) ? 4'h9 : {3'h0, i == 0};
        wr(5'h0f, {i[1:0], 2'h0, pg});
        check({window_kind, window_page}, {i[1:0], pg});
        rd(5'h13, 8'h00);
        check(win_mem_addr, {pg, 4'h3});
      end
    end
  endtask
  task t_period(input [4:0] code, input [31:0] per, input [31:0] hi, input slw);
    integer n, h, r0;
    begin
      wr(5'h04, 8'h05);
      wr(5'h0c, 8'h80);
      wr(5'h0d, {3'h0, code});
      r0 = byte_ring;
      ticks = 0;
      @(posedge core_clk);
      slow <= slw;
      data_phase <= 1'b1;
      sync_run <= 1'b1;
      n = 0;
      while (period_tick !== 1'b1 && n < 80) begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      n = 0;
      h = 0;
      while ((n == 0 || period_tick !== 1'b1) && n < 80) begin
        n = n + 1;
        h = h + req_ack_level;
        @(posedge core_clk);
        #1;
      end
      check(n, per);
      check(h, hi);
      @(posedge core_clk);
      sync_run <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      check((r0 - byte_ring) & 63, ticks & 63);
    end
  endtask
  task t_banned;
    begin
      wr(5'h0d, 8'h01);
      ticks = 0;
      @(posedge core_clk);
      sync_run <= 1'b1;
      repeat (40) @(posedge core_clk);
      sync_run <= 1'b0;
      check(ticks, 0);
    end
  endtask
  task finish_test;
    begin
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Main sequence after the reset span.
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_per_id;
    t_view;
    t_ring;
    t_window;
    t_period(5'h04, 4, 2, 1'b0);
    t_period(5'h05, 5, 3, 1'b1);
    t_period(5'h00, 32, 16, 1'b0);
    t_banned;
    finish_test;
  end
  // Watchdog, well beyond the few hundred cycles the sequence needs.
  initial begin
    #200000;
    failures = failures + 1;
    finish_test;
  end
endmodule // stp_regs_top_tb
